// file: core/fpuwi_pkg.sv
// Purpose: constants and types of the flash power-up write inhibit sequencer
// Assumes: 125 MHz core clock; supply monitor gives two level pins
// Notes: counts are derived from printed times, rounded up
package fpuwi_pkg;

    // Timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int SEL_DLY_US = 30;
    localparam int SEL_DLY_CYC =
        (SEL_DLY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int UNLOCK_DLY_MS = 1;
    localparam int UNLOCK_DLY_CYC =
        (UNLOCK_DLY_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SEL_CNT_W = 12;
    localparam int UNLOCK_CNT_W = 24;

    // Delivered values and field positions
    localparam logic [7:0] STATUS_DELIVERED = 8'h00;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam int ST_WIP_BIT = 0;
    localparam int ST_WEL_BIT = 1;
    localparam int LOCK_WR_BIT = 0;
    localparam int LOCK_DN_BIT = 1;

    typedef enum logic [1:0]
    {
        PWR_OFF = 2'b00,
        PWR_WAIT = 2'b01,
        PWR_RUN = 2'b10
    } fpuwi_pwr_e;

    typedef enum logic [3:0]
    {
        NO_CMD = 4'h0,
        READ_CMD = 4'h1,
        WRITE_UNLOCK_CMD = 4'h2,
        PAGE_WRITE_CMD = 4'h3,
        DUAL_IN_PAGE_WRITE_CMD = 4'h4,
        OTP_WRITE_CMD = 4'h5,
        BLOCK4K_WIPE_CMD = 4'h6,
        BLOCK64K_WIPE_CMD = 4'h7,
        WHOLE_ARRAY_WIPE_CMD = 4'h8,
        STATUS_REG_WRITE_CMD = 4'h9,
        LOCK_REG_WRITE_CMD = 4'hA,
        WRITE_RELOCK_CMD = 4'hB,
        DEEP_SLEEP_CMD = 4'hC,
        DEEP_WAKE_CMD = 4'hD
    } fpuwi_cmd_e;

    // Commands held back until the unlock delay has run
    function automatic logic fpuwi_is_write(input fpuwi_cmd_e k);
        return k inside {WRITE_UNLOCK_CMD, PAGE_WRITE_CMD,
            DUAL_IN_PAGE_WRITE_CMD, OTP_WRITE_CMD, BLOCK4K_WIPE_CMD,
            BLOCK64K_WIPE_CMD, WHOLE_ARRAY_WIPE_CMD, STATUS_REG_WRITE_CMD,
            LOCK_REG_WRITE_CMD};
    endfunction

    // Commands that start a self-timed cycle
    function automatic logic fpuwi_is_cycle(input fpuwi_cmd_e k);
        return k inside {PAGE_WRITE_CMD, DUAL_IN_PAGE_WRITE_CMD,
            OTP_WRITE_CMD, BLOCK4K_WIPE_CMD, BLOCK64K_WIPE_CMD,
            WHOLE_ARRAY_WIPE_CMD, STATUS_REG_WRITE_CMD};
    endfunction

endpackage

// file: core/fpuwi_seq.sv
// Purpose: power-up / power-down sequencing and write inhibit
// Assumes: command kinds come decoded on CLK_IN; supply pins are async
// Notes: serial clock and select are sampled to watch host timing
`timescale 1ns/1ns
module fpuwi_seq
#(
    parameter int UNLOCK_CYC = fpuwi_pkg::UNLOCK_DLY_CYC
)
(
    input wire logic CLK_IN,
    input wire logic NRST_IN,
    input wire logic CE_IN,
    input wire logic SUPPLY_ABOVE_WI_IN,
    input wire logic SUPPLY_AT_MIN_IN,
    input wire logic SPI_CLK_IN,
    input wire logic SPI_SEL_N_IN,
    input wire logic CMD_VALID_IN,
    input wire fpuwi_pkg::fpuwi_cmd_e CMD_KIND_IN,
    input wire logic [1:0] CMD_LOCK_DATA_IN,
    input wire logic CYCLE_DONE_IN,
    output logic LOGIC_RESET_OUT,
    output logic OPS_ENABLE_OUT,
    output logic READ_ALLOW_OUT,
    output logic WRITE_ALLOW_OUT,
    output logic CMD_ACCEPT_OUT,
    output logic CMD_DISCARD_OUT,
    output logic DEEP_SLEEP_OUT,
    output logic WRITE_ENABLE_LATCH_FLAG_OUT,
    output logic WRITE_IN_PROGRESS_FLAG_OUT,
    output logic [7:0] STATUS_OUT,
    output logic LOCK_WRITE_BIT_OUT,
    output logic LOCK_DOWN_BIT_OUT,
    output logic [7:0] ERASED_FILL_OUT,
    output logic HOST_EARLY_SEL_OUT,
    output logic DATA_AT_RISK_OUT
);
    import fpuwi_pkg::*;

    localparam logic [SEL_CNT_W-1:0] SEL_LAST =
        SEL_CNT_W'(SEL_DLY_CYC - 1);
    localparam logic [UNLOCK_CNT_W-1:0] UNLOCK_LAST =
        UNLOCK_CNT_W'(UNLOCK_CYC - 1);

    logic [3:0] sync1;
    logic [3:0] sync2;
    logic spi_clk_prev;
    logic above_s;
    logic min_s;
    logic sel_low_s;
    logic spi_rise;
    fpuwi_pwr_e state;
    fpuwi_pwr_e next_state;
    logic [SEL_CNT_W-1:0] sel_cnt;
    logic [UNLOCK_CNT_W-1:0] unlock_cnt;
    logic sel_done;
    logic unlock_done;
    logic acc;
    logic next_wel;
    logic next_wip;

    ////////////////////////////////////////////////////////////////////////
    // Two-flop synchronisers for supply, select and serial clock pins
    always_ff @(posedge CLK_IN)
    begin
        if (!NRST_IN)
        begin
            sync1 <= 4'h0;
            sync2 <= 4'h0;
            spi_clk_prev <= 1'b0;
        end
        else if (CE_IN)
        begin
            sync1 <= {SPI_CLK_IN, !SPI_SEL_N_IN, SUPPLY_AT_MIN_IN,
                SUPPLY_ABOVE_WI_IN};
            sync2 <= sync1;
            spi_clk_prev <= sync2[3];
        end
    end

    assign above_s = sync2[0];
    assign min_s = sync2[1] && sync2[0];
    assign sel_low_s = sync2[2];
    assign spi_rise = sync2[3] && !spi_clk_prev;

    ////////////////////////////////////////////////////////////////////////
    // Power state: off below threshold, waiting, then running
    always_comb
    begin
        next_state = state;
        case (state)
            PWR_OFF:
                if (above_s)
                    next_state = PWR_WAIT;
            PWR_WAIT:
                if (!above_s)
                    next_state = PWR_OFF;
                else if (unlock_done)
                    next_state = PWR_RUN;
            PWR_RUN:
                if (!above_s)
                    next_state = PWR_OFF;
            default:
                next_state = PWR_OFF;
        endcase
    end

    always_ff @(posedge CLK_IN)
    begin
        if (!NRST_IN)
            state <= PWR_OFF;
        else if (CE_IN)
            state <= next_state;
    end

    ////////////////////////////////////////////////////////////////////////
    // Select delay counter, runs once supply is at minimum
    always_ff @(posedge CLK_IN)
    begin
        if (!NRST_IN)
        begin
            sel_cnt <= '0;
            sel_done <= 1'b0;
        end
        else if (CE_IN)
        begin
            if (!min_s)
            begin
                sel_cnt <= '0;
                sel_done <= 1'b0;
            end
            else if (!sel_done)
            begin
                sel_cnt <= sel_cnt + 1'b1;
                sel_done <= (sel_cnt == SEL_LAST);
            end
        end
    end

    // Unlock delay counter, runs from the threshold crossing
    always_ff @(posedge CLK_IN)
    begin
        if (!NRST_IN)
        begin
            unlock_cnt <= '0;
            unlock_done <= 1'b0;
        end
        else if (CE_IN)
        begin
            if (!above_s)
            begin
                unlock_cnt <= '0;
                unlock_done <= 1'b0;
            end
            else if (!unlock_done)
            begin
                unlock_cnt <= unlock_cnt + 1'b1;
                unlock_done <= (unlock_cnt == UNLOCK_LAST);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Command gating: writes wait for unlock, others for select delay
    always_comb
    begin
        acc = 1'b0;
        if (CMD_VALID_IN && state != PWR_OFF && above_s)
        begin
            if (fpuwi_is_write(CMD_KIND_IN))
                acc = unlock_done && !DEEP_SLEEP_OUT;
            else if (DEEP_SLEEP_OUT)
                acc = (CMD_KIND_IN == DEEP_WAKE_CMD);
            else
                acc = sel_done && CMD_KIND_IN != NO_CMD;
        end
    end

    // Registered access state and command answers
    always_ff @(posedge CLK_IN)
    begin
        if (!NRST_IN)
        begin
            LOGIC_RESET_OUT <= 1'b1;
            OPS_ENABLE_OUT <= 1'b0;
            READ_ALLOW_OUT <= 1'b0;
            WRITE_ALLOW_OUT <= 1'b0;
            CMD_ACCEPT_OUT <= 1'b0;
            CMD_DISCARD_OUT <= 1'b0;
        end
        else if (CE_IN)
        begin
            LOGIC_RESET_OUT <= (state == PWR_OFF);
            OPS_ENABLE_OUT <= (state != PWR_OFF);
            READ_ALLOW_OUT <= (state != PWR_OFF) && sel_done;
            WRITE_ALLOW_OUT <= (state == PWR_RUN);
            CMD_ACCEPT_OUT <= acc;
            CMD_DISCARD_OUT <= CMD_VALID_IN && !acc;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Latch and progress flags with status image
    always_comb
    begin
        next_wel = WRITE_ENABLE_LATCH_FLAG_OUT;
        next_wip = WRITE_IN_PROGRESS_FLAG_OUT;
        if (CYCLE_DONE_IN)
            next_wip = 1'b0;
        if (acc && CMD_KIND_IN == WRITE_UNLOCK_CMD && !next_wip)
            next_wel = 1'b1;
        else if (acc && CMD_KIND_IN == WRITE_RELOCK_CMD && !next_wip)
            next_wel = 1'b0;
        else if (acc && fpuwi_is_cycle(CMD_KIND_IN) && next_wel && !next_wip)
        begin
            next_wel = 1'b0;
            next_wip = 1'b1;
        end
    end

    always_ff @(posedge CLK_IN)
    begin
        if (!NRST_IN || (CE_IN && state == PWR_OFF))
        begin
            WRITE_ENABLE_LATCH_FLAG_OUT <= 1'b0;
            WRITE_IN_PROGRESS_FLAG_OUT <= 1'b0;
            STATUS_OUT <= STATUS_DELIVERED;
        end
        else if (CE_IN)
        begin
            WRITE_ENABLE_LATCH_FLAG_OUT <= next_wel;
            WRITE_IN_PROGRESS_FLAG_OUT <= next_wip;
            STATUS_OUT <= STATUS_DELIVERED;
            STATUS_OUT[ST_WEL_BIT] <= next_wel;
            STATUS_OUT[ST_WIP_BIT] <= next_wip;
        end
    end

    // Deep sleep and lock bits, cleared at every power-up
    always_ff @(posedge CLK_IN)
    begin
        if (!NRST_IN || (CE_IN && state == PWR_OFF))
        begin
            DEEP_SLEEP_OUT <= 1'b0;
            LOCK_WRITE_BIT_OUT <= 1'b0;
            LOCK_DOWN_BIT_OUT <= 1'b0;
        end
        else if (CE_IN && acc)
        begin
            if (CMD_KIND_IN == DEEP_SLEEP_CMD && !WRITE_IN_PROGRESS_FLAG_OUT)
                DEEP_SLEEP_OUT <= 1'b1;
            else if (CMD_KIND_IN == DEEP_WAKE_CMD)
                DEEP_SLEEP_OUT <= 1'b0;
            if (CMD_KIND_IN == LOCK_REG_WRITE_CMD && WRITE_ENABLE_LATCH_FLAG_OUT
                && !LOCK_DOWN_BIT_OUT)
            begin
                LOCK_WRITE_BIT_OUT <= CMD_LOCK_DATA_IN[LOCK_WR_BIT];
                LOCK_DOWN_BIT_OUT <= CMD_LOCK_DATA_IN[LOCK_DN_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Host timing watch, supply-drop hazard and erased fill value
    always_ff @(posedge CLK_IN)
    begin
        if (!NRST_IN)
        begin
            HOST_EARLY_SEL_OUT <= 1'b0;
            DATA_AT_RISK_OUT <= 1'b0;
            ERASED_FILL_OUT <= ERASED_BYTE;
        end
        else if (CE_IN)
        begin
            if (!sel_done && (sel_low_s || spi_rise))
                HOST_EARLY_SEL_OUT <= 1'b1;
            if (!above_s && WRITE_IN_PROGRESS_FLAG_OUT)
                DATA_AT_RISK_OUT <= 1'b1;
            ERASED_FILL_OUT <= ERASED_BYTE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (!NRST_IN || !CE_IN);

    sequence seq_drop;
        above_s ##1 !above_s;
    endsequence

    sequence seq_wr_early;
        CMD_VALID_IN && fpuwi_is_write(CMD_KIND_IN) && !unlock_done;
    endsequence

    a_off_silent: assert property ((state == PWR_OFF) |=>
        !CMD_ACCEPT_OUT && LOGIC_RESET_OUT)
        else $error("command accepted below threshold");
    a_write_hold: assert property (seq_wr_early |=>
        CMD_DISCARD_OUT && !CMD_ACCEPT_OUT)
        else $error("write accepted before unlock delay");
    a_read_open: assert property ((CMD_VALID_IN && CMD_KIND_IN == READ_CMD
        && sel_done && state != PWR_OFF && above_s && !DEEP_SLEEP_OUT)
        |=> CMD_ACCEPT_OUT)
        else $error("read refused after select delay");
    a_read_closed: assert property (!sel_done |=> !READ_ALLOW_OUT)
        else $error("read allowed before select delay");
    a_sel_count: assert property ($rose(sel_done) |->
        sel_cnt == SEL_CNT_W'(SEL_DLY_CYC) && $past(min_s, 1))
        else $error("select delay count wrong");
    a_unlock_count: assert property ($rose(unlock_done) |->
        unlock_cnt == UNLOCK_CNT_W'(UNLOCK_CYC))
        else $error("unlock delay count wrong");
    a_powerup_clear: assert property ($fell(LOGIC_RESET_OUT) |->
        !WRITE_ENABLE_LATCH_FLAG_OUT && !WRITE_IN_PROGRESS_FLAG_OUT
        && !DEEP_SLEEP_OUT && !LOCK_WRITE_BIT_OUT && !LOCK_DOWN_BIT_OUT)
        else $error("power-up state not clear");
    a_drop_off: assert property (seq_drop |-> ##2
        LOGIC_RESET_OUT && !OPS_ENABLE_OUT && !WRITE_ALLOW_OUT)
        else $error("operations live after supply drop");
    a_status_init: assert property (LOGIC_RESET_OUT |->
        STATUS_OUT == STATUS_DELIVERED && ERASED_FILL_OUT == ERASED_BYTE)
        else $error("delivered status or fill wrong");

endmodule

// file: testbench/fpuwi_host_model.sv
// Purpose: host side of the link, select and serial clock only
// Assumes: bench asks for a frame through frame_in
// Notes: serial clock stands low outside frames
`timescale 1ns/1ns
module fpuwi_host_model
(
    input wire logic frame_in,
    output logic spi_clk_out,
    output logic spi_sel_n_out
);
    logic clk_q = 1'b0;

    ////////////////////////////////////////////////////////////////////
    // Select held high outside a requested frame
    assign spi_sel_n_out = !frame_in;
    assign spi_clk_out = clk_q;

    // Serial clock of 160 ns period, runs only within a frame
    always
    begin
        #80;
        clk_q = frame_in ? !clk_q : 1'b0;
    end
endmodule

// file: testbench/flash_power_up_write_inhibit_tb.sv
// Purpose: self-checking bench of the power-up write inhibit sequencer
// Assumes: unlock delay shortened to 5000 cycles, longer than select
// Notes: inputs change at the falling edge only
`timescale 1ns/1ns
module flash_power_up_write_inhibit_tb;
    import fpuwi_pkg::*;
    localparam int UNLOCK = 5000;
    localparam int LIMIT = 12000;
    logic clk = 0, nrst = 0, valid = 0, above = 0, at_min = 0;
    logic frame = 0, done = 0, ce = 1, spi_clk, spi_sel_n;
    logic [1:0] lock_d = 2'b00;
    fpuwi_cmd_e kind = NO_CMD;
    logic rst_o, ops, rd_ok, wr_ok, acc, dis, deep, write_enable_latch_flag, write_in_progress_flag;
    logic lk_wr, lk_dn, early, risk;
    logic [7:0] status, fill;
    int miscompares = 0, comparisons = 0, cycles = 0, t0, dt;
    fpuwi_cmd_e wcmd[9] = '{WRITE_UNLOCK_CMD, PAGE_WRITE_CMD,
        DUAL_IN_PAGE_WRITE_CMD, OTP_WRITE_CMD, BLOCK4K_WIPE_CMD,
        BLOCK64K_WIPE_CMD, WHOLE_ARRAY_WIPE_CMD, STATUS_REG_WRITE_CMD,
        LOCK_REG_WRITE_CMD};

    fpuwi_seq #(.UNLOCK_CYC(UNLOCK)) u_fpuwi_seq
    (
        .CLK_IN(clk), .NRST_IN(nrst), .CE_IN(ce),
        .SUPPLY_ABOVE_WI_IN(above), .SUPPLY_AT_MIN_IN(at_min),
        .SPI_CLK_IN(spi_clk), .SPI_SEL_N_IN(spi_sel_n),
        .CMD_VALID_IN(valid), .CMD_KIND_IN(kind),
        .CMD_LOCK_DATA_IN(lock_d), .CYCLE_DONE_IN(done),
        .LOGIC_RESET_OUT(rst_o), .OPS_ENABLE_OUT(ops),
        .READ_ALLOW_OUT(rd_ok), .WRITE_ALLOW_OUT(wr_ok),
        .CMD_ACCEPT_OUT(acc), .CMD_DISCARD_OUT(dis),
        .DEEP_SLEEP_OUT(deep), .WRITE_ENABLE_LATCH_FLAG_OUT(write_enable_latch_flag),
        .WRITE_IN_PROGRESS_FLAG_OUT(write_in_progress_flag), .STATUS_OUT(status),
        .LOCK_WRITE_BIT_OUT(lk_wr), .LOCK_DOWN_BIT_OUT(lk_dn),
        .ERASED_FILL_OUT(fill), .HOST_EARLY_SEL_OUT(early),
        .DATA_AT_RISK_OUT(risk)
    );

    fpuwi_host_model u_fpuwi_host_model
    (
        .frame_in(frame), .spi_clk_out(spi_clk),
        .spi_sel_n_out(spi_sel_n)
    );

    ////////////////////////////////////////////////////////////////////
    // Clock and hang guard
    always #4 clk = ~clk;

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == LIMIT)
        begin
            miscompares = miscompares + 1;
            final_report();
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic final_report();
        if (miscompares == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] seen,
        input logic [15:0] exp);
        comparisons = comparisons + 1;
        if (seen !== exp)
        begin
            miscompares = miscompares + 1;
            $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    // One command pulse, registered answer looked at one cycle later as valid drops
    task automatic cmd(input fpuwi_cmd_e k, input logic ok);
        @(negedge clk);
        valid = 1'b1;
        kind = k;
        @(negedge clk);
        valid = 1'b0;
        chk("accept", acc, ok);
        chk("discard", dis, !ok);
    endtask

    // Bounded wait for read or write permission
    task automatic wait_hi(input logic w);
        int k;
        k = 0;
        while ((w ? wr_ok : rd_ok) !== 1'b1 && k < 6000)
        begin
            @(negedge clk);
            k++;
        end
    endtask

    ////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        repeat (10) @(negedge clk);
        nrst = 1'b1;
        @(negedge clk);
        chk("reset", rst_o, 1);
        chk("fill", fill, ERASED_BYTE);
        chk("status", status, STATUS_DELIVERED);
        cmd(READ_CMD, 0);
        above = 1'b1;
        at_min = 1'b1;
        t0 = cycles;
        repeat (6) @(negedge clk);
        chk("ops", {rst_o, ops}, 2'b01);
        foreach (wcmd[i]) cmd(wcmd[i], 0);
        wait_hi(0);
        dt = cycles - t0;
        chk("sel_dly", dt >= SEL_DLY_CYC && dt < SEL_DLY_CYC + 8, 1);
        chk("wr_ok", wr_ok, 0);
        frame = 1'b1;
        cmd(READ_CMD, 1);
        cmd(PAGE_WRITE_CMD, 0);
        frame = 1'b0;
        chk("early", early, 0);
        wait_hi(1);
        dt = cycles - t0;
        chk("wr_open", wr_ok, 1);
        chk("unl_dly", dt >= UNLOCK && dt < UNLOCK + 8, 1);
        chk("idle", {deep, write_enable_latch_flag, write_in_progress_flag, lk_wr, lk_dn}, 0);
        cmd(WRITE_UNLOCK_CMD, 1);
        chk("status", status, 8'h02);
        lock_d = 2'b11;
        cmd(LOCK_REG_WRITE_CMD, 1);
        chk("lock", {lk_wr, lk_dn}, 2'b11);
        cmd(DEEP_SLEEP_CMD, 1);
        chk("deep", deep, 1);
        cmd(WRITE_UNLOCK_CMD, 0);
        cmd(DEEP_WAKE_CMD, 1);
        cmd(WRITE_UNLOCK_CMD, 1);
        cmd(PAGE_WRITE_CMD, 1);
        chk("status", status, 8'h01);
        // Clock enable low freezes, then the cycle ends
        ce = 1'b0;
        done = 1'b1;
        repeat (3) @(negedge clk);
        chk("frozen", {write_in_progress_flag, status}, 9'h101);
        ce = 1'b1;
        @(negedge clk);
        done = 1'b0;
        chk("wip_end", {write_in_progress_flag, status}, 9'h000);
        cmd(NO_CMD, 0);
        cmd(WRITE_UNLOCK_CMD, 1);
        cmd(WRITE_RELOCK_CMD, 1);
        chk("relock", write_enable_latch_flag, 0);
        cmd(WRITE_UNLOCK_CMD, 1);
        cmd(PAGE_WRITE_CMD, 1);
        chk("wip", write_in_progress_flag, 1);
        // Supply lost in mid-cycle
        above = 1'b0;
        at_min = 1'b0;
        repeat (6) @(negedge clk);
        chk("off", {rst_o, ops, rd_ok, wr_ok}, 4'b1000);
        chk("risk", risk, 1);
        cmd(READ_CMD, 0);
        // Second power-up, host selects too early on purpose
        above = 1'b1;
        at_min = 1'b1;
        frame = 1'b1;
        repeat (40) @(negedge clk);
        frame = 1'b0;
        chk("early", early, 1);
        wait_hi(0);
        chk("idle", {deep, write_enable_latch_flag, write_in_progress_flag, lk_wr, lk_dn, status}, 0);
        final_report();
    end
endmodule
